// *** shared/lclf_pkg.sv ***
// Purpose: constants, field layouts and types of the lock current-limit fault block
// Assumes: 20 MHz system clock, APB register access with 32-bit data
// Notes: currents are in units of 1/8 A, times in 0.05 ms ticks
package lclf_pkg;
	localparam int CLK_NS = 50;
	localparam int TICK_NS = 50000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	localparam int RETRY_STEP_NS = 10000000;
	localparam int RETRY_STEP_TICKS = RETRY_STEP_NS / TICK_NS;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_RETRY = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_CLEAR = 8'h0c;
	localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
	localparam logic [31:0] RETRY_RESET = 32'h0000_0000;
	localparam int CLEAR_BIT = 0;
	localparam logic [3:0] MODE_AUTO_FIRST = 4'h4;
	localparam logic [3:0] MODE_REPORT = 4'h8;

	// lock_fault_config layout, msb first
	typedef struct packed {
		logic parity;
		logic [3:0] torqueLimit;
		logic [3:0] comparatorLockThreshold;
		logic [3:0] adcLockThreshold;
		logic [3:0] lockMode;
		logic [3:0] lockDeglitchTime;
		logic [10:0] otherBits;
	} lclf_cfg_t;

	typedef struct packed {
		logic [23:0] reserved;
		logic [3:0] retryCountLimit;
		logic [3:0] lockRetryInterval;
	} lclf_retry_t;

	typedef enum logic [2:0] {
		GATE_RUN = 3'b000,
		GATE_TRISTATE = 3'b001,
		GATE_RECIRC = 3'b010,
		GATE_HS_BRAKE = 3'b011,
		GATE_LS_BRAKE = 3'b100
	} lclf_gate_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RETRY = 2'b01,
		ST_LATCHED = 2'b10,
		ST_REPORT = 2'b11
	} lclf_state_t;

	typedef struct packed {
		logic [21:0] reserved;
		logic [3:0] retryCount;
		lclf_gate_t gate;
		lclf_state_t state;
		logic lockCond;
	} lclf_status_t;

	// threshold code to current in 1/8 A
	function automatic logic [6:0] thrEighths(input logic [3:0] code);
		case (code)
			4'h0: thrEighths = 7'h01;
			4'h1: thrEighths = 7'h02;
			4'h2: thrEighths = 7'h04;
			4'he: thrEighths = 7'h38;
			4'hf: thrEighths = 7'h40;
			default: thrEighths = (7'(code) - 7'h01) << 2;
		endcase
	endfunction

	// deglitch code to 0.05 ms ticks
	function automatic logic [14:0] degTicks(input logic [3:0] code);
		case (code)
			4'h0: degTicks = 15'h0001;
			4'h1: degTicks = 15'h0002;
			4'h2: degTicks = 15'h0004;
			4'h3: degTicks = 15'h000a;
			4'h4: degTicks = 15'h0014;
			4'h5: degTicks = 15'h0032;
			4'h6: degTicks = 15'h0064;
			4'h7: degTicks = 15'h0096;
			4'h8: degTicks = 15'h00c8;
			4'h9: degTicks = 15'h01f4;
			4'ha: degTicks = 15'h03e8;
			4'hb: degTicks = 15'h05dc;
			4'hc: degTicks = 15'h07d0;
			4'hd: degTicks = 15'h0fa0;
			4'he: degTicks = 15'h2710;
			default: degTicks = 15'h4e20;
		endcase
	endfunction

	function automatic lclf_gate_t gateOf(input logic [1:0] sel);
		case (sel)
			2'h0: gateOf = GATE_TRISTATE;
			2'h1: gateOf = GATE_RECIRC;
			2'h2: gateOf = GATE_HS_BRAKE;
			default: gateOf = GATE_LS_BRAKE;
		endcase
	endfunction
endpackage

// *** hw/lclf_lock_fault.sv ***
// Purpose: motor-lock current-limit detection and fault response with auto retry
// Assumes: APB slave, comparator flag arrives asynchronously, ADC samples on this clock
// Notes: gate command and fault indicator come from flip-flops
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
module lclf_lock_fault #(
	parameter int TICK_LEN = lclf_pkg::TICK_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lclf_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cmpOverPin,
	input wire logic [7:0] adcCurrent,
	input wire logic adcValid,
	output logic [3:0] cmpThreshold,
	output lclf_pkg::lclf_gate_t gateCmd,
	output logic faultN
);
	import lclf_pkg::*;

	lclf_cfg_t lockFaultConfig;
	lclf_retry_t retryCfg;
	lclf_state_t state;
	logic apbAccess;
	logic apbWrite;
	logic mapped;
	logic swClear;
	logic cmpMeta;
	logic cmpSync;
	logic adcAbove;
	logic detectOn;
	logic lockCond;
	logic lockEvent;
	logic [15:0] tickCount;
	logic tick;
	logic [14:0] degCount;
	logic [15:0] retryTimer;
	logic [15:0] retryLen;
	logic retryExpire;
	logic [3:0] retryCount;
	logic limitReached;
	lclf_status_t status;

	// apb slave: zero wait states, unmapped access answers with pslverr
	assign apbAccess = psel && penable;
	assign apbWrite = apbAccess && pwrite;
	assign mapped = paddr == OFS_CONFIG || paddr == OFS_RETRY || paddr == OFS_STATUS ||
		paddr == OFS_CLEAR;
	assign pready = 1'b1;
	assign pslverr = apbAccess && !mapped;
	assign swClear = apbWrite && paddr == OFS_CLEAR && pwdata[CLEAR_BIT];

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			lockFaultConfig <= CONFIG_RESET;
		end else if (apbWrite && paddr == OFS_CONFIG) begin
			lockFaultConfig <= pwdata;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			retryCfg <= RETRY_RESET;
		end else if (apbWrite && paddr == OFS_RETRY) begin
			retryCfg <= {24'h000000, pwdata[7:0]};
		end
	end

	assign status = '{reserved: '0, retryCount: retryCount, gate: gateCmd, state: state,
		lockCond: lockCond};

	// read data is captured in the setup cycle so it stands through the access phase
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (paddr)
				OFS_CONFIG: prdata <= lockFaultConfig;
				OFS_RETRY: prdata <= retryCfg;
				OFS_STATUS: prdata <= status;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	assign cmpThreshold = lockFaultConfig.comparatorLockThreshold;

	// comparator flag is asynchronous to this clock
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			cmpMeta <= 1'b0;
			cmpSync <= 1'b0;
		end else begin
			cmpMeta <= cmpOverPin;
			cmpSync <= cmpMeta;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			adcAbove <= 1'b0;
		end else if (adcValid) begin
			adcAbove <= adcCurrent > {1'b0, thrEighths(lockFaultConfig.adcLockThreshold)};
		end
	end

	// codes above report-only switch detection off entirely
	assign detectOn = lockFaultConfig.lockMode <= MODE_REPORT;
	assign lockCond = detectOn && (cmpSync || adcAbove);

	// 0.05 ms time base; the length is a parameter so simulation can shorten it
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			tickCount <= 16'h0000;
		end else if (tickCount == 16'(TICK_LEN - 1)) begin
			tickCount <= 16'h0000;
		end else begin
			tickCount <= tickCount + 16'h0001;
		end
	end
	assign tick = tickCount == 16'(TICK_LEN - 1);

	// any dip below threshold restarts the deglitch window
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			degCount <= 15'h0000;
		end else if (!lockCond || state != ST_IDLE) begin
			degCount <= 15'h0000;
		end else if (tick && degCount < degTicks(lockFaultConfig.lockDeglitchTime)) begin
			degCount <= degCount + 15'h0001;
		end
	end
	assign lockEvent = state == ST_IDLE && lockCond &&
		degCount >= degTicks(lockFaultConfig.lockDeglitchTime);

	assign retryLen = 16'(({12'h000, retryCfg.lockRetryInterval} + 16'h0001) * RETRY_STEP_TICKS);
	assign retryExpire = state == ST_RETRY && retryTimer >= retryLen;
	assign limitReached = retryCount >= retryCfg.retryCountLimit;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			retryTimer <= 16'h0000;
		end else if (state != ST_RETRY) begin
			retryTimer <= 16'h0000;
		end else if (tick) begin
			retryTimer <= retryTimer + 16'h0001;
		end
	end

	// a lock event that takes an auto retry beats a software clear arriving in the same cycle
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			retryCount <= 4'h0;
		end else if (lockEvent && lockFaultConfig.lockMode >= MODE_AUTO_FIRST &&
			lockFaultConfig.lockMode < MODE_REPORT && !limitReached) begin
			retryCount <= retryCount + 4'h1;
		end else if (swClear) begin
			retryCount <= 4'h0;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state <= ST_IDLE;
		end else if (lockEvent) begin
			if (lockFaultConfig.lockMode == MODE_REPORT) begin
				state <= ST_REPORT;
			end else if (lockFaultConfig.lockMode < MODE_AUTO_FIRST || limitReached) begin
				state <= ST_LATCHED;
			end else begin
				state <= ST_RETRY;
			end
		end else if (swClear || retryExpire) begin
			state <= ST_IDLE;
		end
	end

	// mode bits 1:0 pick the drive action both while retrying and once latched
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			gateCmd <= GATE_RUN;
		end else if (lockEvent && lockFaultConfig.lockMode != MODE_REPORT) begin
			gateCmd <= gateOf(lockFaultConfig.lockMode[1:0]);
		end else if (swClear || retryExpire) begin
			gateCmd <= GATE_RUN;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			faultN <= 1'b1;
		end else if (lockEvent) begin
			faultN <= 1'b0;
		end else if (swClear || retryExpire) begin
			faultN <= 1'b1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// run length of the lock condition in cycles, kept apart from the tick counter so the
	// deglitch checks do not lean on the logic they guard
	logic [31:0] condCycles;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			condCycles <= 32'h0000_0000;
		end else if (!lockCond || state != ST_IDLE) begin
			condCycles <= 32'h0000_0000;
		end else begin
			condCycles <= condCycles + 32'h0000_0001;
		end
	end

	property p_cmpThreshold;
		apbWrite && paddr == OFS_CONFIG |=> cmpThreshold == $past(pwdata[26:23]);
	endproperty
	a_cmpThreshold: assert property (p_cmpThreshold) else $error("comparator threshold wrong");

	property p_adcAbove;
		adcValid |=> adcAbove ==
			($past(adcCurrent) > {1'b0, thrEighths($past(lockFaultConfig.adcLockThreshold))});
	endproperty
	a_adcAbove: assert property (p_adcAbove) else $error("adc compare wrong");

	property p_latchTri;
		lockEvent && lockFaultConfig.lockMode == 4'h0 |=> state == ST_LATCHED &&
			gateCmd == GATE_TRISTATE && !faultN;
	endproperty
	a_latchTri: assert property (p_latchTri) else $error("mode 0 response wrong");

	property p_latchRecirc;
		lockEvent && lockFaultConfig.lockMode == 4'h1 |=> state == ST_LATCHED &&
			gateCmd == GATE_RECIRC && !faultN;
	endproperty
	a_latchRecirc: assert property (p_latchRecirc) else $error("mode 1 response wrong");

	property p_latchHs;
		lockEvent && lockFaultConfig.lockMode == 4'h2 |=> state == ST_LATCHED &&
			gateCmd == GATE_HS_BRAKE;
	endproperty
	a_latchHs: assert property (p_latchHs) else $error("mode 2 response wrong");

	property p_latchLs;
		lockEvent && lockFaultConfig.lockMode == 4'h3 |=> state == ST_LATCHED &&
			gateCmd == GATE_LS_BRAKE;
	endproperty
	a_latchLs: assert property (p_latchLs) else $error("mode 3 response wrong");

	property p_autoTri;
		lockEvent && lockFaultConfig.lockMode == 4'h4 |=> gateCmd == GATE_TRISTATE && !faultN &&
			state == ($past(limitReached) ? ST_LATCHED : ST_RETRY);
	endproperty
	a_autoTri: assert property (p_autoTri) else $error("mode 4 response wrong");

	property p_autoRecirc;
		lockEvent && lockFaultConfig.lockMode == 4'h5 && limitReached |=> state == ST_LATCHED &&
			gateCmd == GATE_RECIRC;
	endproperty
	a_autoRecirc: assert property (p_autoRecirc) else $error("mode 5 limit wrong");

	property p_retryRelease;
		retryExpire && !lockEvent |=> state == ST_IDLE && faultN && gateCmd == GATE_RUN;
	endproperty
	a_retryRelease: assert property (p_retryRelease) else $error("retry release wrong");

	property p_autoLs;
		lockEvent && lockFaultConfig.lockMode == 4'h7 && !limitReached |=> state == ST_RETRY &&
			gateCmd == GATE_LS_BRAKE && retryCount == $past(retryCount) + 4'h1;
	endproperty
	a_autoLs: assert property (p_autoLs) else $error("mode 7 retry wrong");

	property p_reportOnly;
		lockEvent && lockFaultConfig.lockMode == MODE_REPORT |=> state == ST_REPORT && !faultN &&
			gateCmd == $past(gateCmd);
	endproperty
	a_reportOnly: assert property (p_reportOnly) else $error("report mode drove gates");

	property p_disabled;
		lockFaultConfig.lockMode > MODE_REPORT |-> !lockEvent;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled mode raised event");

	property p_deglitch;
		lockEvent |-> condCycles >=
			(32'(degTicks(lockFaultConfig.lockDeglitchTime)) - 32'h1) * 32'(TICK_LEN) + 32'h1;
	endproperty
	a_deglitch: assert property (p_deglitch) else $error("event without full deglitch");

	// a run as long as the whole deglitch time must have raised the event by now
	property p_deglitchMax;
		state == ST_IDLE && lockCond &&
			condCycles >= 32'(degTicks(lockFaultConfig.lockDeglitchTime)) * 32'(TICK_LEN) |-> lockEvent;
	endproperty
	a_deglitchMax: assert property (p_deglitchMax) else $error("deglitch ran past its time");

	property p_dipRestarts;
		state == ST_IDLE && !lockCond |=> degCount == 15'h0000;
	endproperty
	a_dipRestarts: assert property (p_dipRestarts) else $error("deglitch not restarted");

	property p_clearCount;
		swClear && !lockEvent |=> retryCount == 4'h0 && state == ST_IDLE;
	endproperty
	a_clearCount: assert property (p_clearCount) else $error("clear did not zero retries");

	property p_faultHold;
		state != ST_IDLE && !swClear && !retryExpire |=> !faultN && state == $past(state);
	endproperty
	a_faultHold: assert property (p_faultHold) else $error("fault released on its own");

	property p_autoHs;
		lockEvent && lockFaultConfig.lockMode == 4'h6 |=> gateCmd == GATE_HS_BRAKE && !faultN;
	endproperty
	a_autoHs: assert property (p_autoHs) else $error("mode 6 response wrong");

	// once the limit is reached the count stands until software or reset clears it
	property p_limitHold;
		lockEvent && limitReached && !swClear |=> retryCount == $past(retryCount);
	endproperty
	a_limitHold: assert property (p_limitHold) else $error("retry count ran past limit");

	property p_retryRecirc;
		lockEvent && lockFaultConfig.lockMode == 4'h5 && !limitReached |=> state == ST_RETRY &&
			gateCmd == GATE_RECIRC && !faultN;
	endproperty
	a_retryRecirc: assert property (p_retryRecirc) else $error("mode 5 retry wrong");

	c_latched: cover property (lockEvent && lockFaultConfig.lockMode < MODE_AUTO_FIRST ##1
		state == ST_LATCHED);
	c_retryDone: cover property (state == ST_RETRY ##1 state == ST_IDLE);
	c_limitLatch: cover property (lockEvent && lockFaultConfig.lockMode == 4'h4 && limitReached);
	c_report: cover property (state == ST_REPORT ##1 swClear);
	c_freshRetry: cover property (swClear && state == ST_LATCHED ##[1:40] state == ST_RETRY);
endmodule

// *** tb/lclf_lock_fault_test.sv ***
// Purpose: self-checking bench for the lock current-limit fault block
// Assumes: TICK_LEN cut to 4 cycles, zero-wait APB slave
// Notes: retry interval code 0 is 200 ticks, so 800 cycles here
module lclf_lock_fault_test;
	timeunit 1ns;
	timeprecision 1ns;
	import lclf_pkg::*;
	localparam int TL = 4;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cmpOverPin = 1'b0;
	logic [7:0] adcCurrent = 8'h00;
	logic adcValid = 1'b0;
	logic [3:0] cmpThreshold;
	lclf_gate_t gateCmd;
	logic faultN;
	int fails = 0;
	int num_checks = 0;
	int n;
	logic [31:0] rd;
	logic er;

	always #25 clock = ~clock;

	lclf_lock_fault #(.TICK_LEN(TL)) lclf_lock_fault_inst (.clock(clock), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cmpOverPin(cmpOverPin),
		.adcCurrent(adcCurrent), .adcValid(adcValid), .cmpThreshold(cmpThreshold),
		.gateCmd(gateCmd), .faultN(faultN));

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// request held until pready is seen high, no wait count assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		bit done;
		done = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		for (int i = 0; i < 20 && !done; i++) begin
			@(posedge clock);
			if (pready === 1'b1) begin
				done = 1;
				rd = prdata;
				er = pslverr;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// let the committing edge settle before the caller looks at outputs
		@(negedge clock);
		if (!done) begin
			fails++;
			summarize();
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic adc(input logic [7:0] v);
		@(posedge clock);
		adcCurrent <= v;
		adcValid <= 1'b1;
		@(posedge clock);
		adcValid <= 1'b0;
	endtask

	task automatic waitN(input logic lvl, input int bound);
		n = 0;
		while (faultN !== lvl && n < bound) begin
			@(posedge clock);
			n++;
		end
		if (faultN !== lvl) begin
			fails++;
			summarize();
		end
	endtask

	function automatic logic [31:0] cfg(input logic [3:0] c, a, m, g);
		return {5'h00, c, a, m, g, 11'h000};
	endfunction

	// expected threshold in 1/8 A, built apart from the design's table
	function automatic logic [7:0] thr(input logic [3:0] c);
		if (c < 4'h3) return 8'h01 << c;
		if (c > 4'hd) return {4'h0, c} * 8'h08 - 8'h38;
		return ({4'h0, c} - 8'h01) << 2;
	endfunction

	task automatic t_regs();
		rdchk(OFS_CONFIG, CONFIG_RESET);
		rdchk(OFS_RETRY, RETRY_RESET);
		rdchk(OFS_STATUS, 32'h0);
		chk({31'h0, faultN}, 32'h1);
		apb(1'b1, OFS_CONFIG, 32'h5a5a_5a5a);
		rdchk(OFS_CONFIG, 32'h5a5a_5a5a);
		chk({28'h0, cmpThreshold}, 32'h4);
		apb(1'b1, 8'h40, 32'h1);
		chk({31'h0, er}, 32'h1);
		rdchk(8'h40, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, OFS_STATUS, 32'hffff_ffff);
		rdchk(OFS_STATUS, 32'h0);
		$display("test regs done");
	endtask

	// report mode keeps gates running, so every code can be swept quickly
	task automatic t_thr();
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, OFS_CONFIG, cfg(c[3:0], c[3:0], 4'h8, 4'h0));
			chk({28'h0, cmpThreshold}, 32'(c));
			adc(thr(c[3:0]));
			rdchk(OFS_STATUS, 32'h0);
			adc(thr(c[3:0]) + 8'h01);
			waitN(1'b0, 100);
			chk(32'(gateCmd), 32'(GATE_RUN));
			rdchk(OFS_STATUS, 32'h7);
			adc(8'h00);
			apb(1'b1, OFS_CLEAR, 32'h1);
		end
		$display("test thresholds done");
	endtask

	task automatic t_deg();
		apb(1'b1, OFS_CONFIG, cfg(4'h0, 4'h0, 4'h0, 4'h2));
		adc(8'hff);
		repeat (6) @(posedge clock);
		adc(8'h00);
		repeat (40) @(posedge clock);
		chk({31'h0, faultN}, 32'h1);
		adc(8'hff);
		waitN(1'b0, 100);
		chk(32'(n >= 10 && n <= 26), 32'h1);
		adc(8'h00);
		apb(1'b1, OFS_CLEAR, 32'h1);
		$display("test deglitch done");
	endtask

	task automatic t_latch();
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, OFS_CONFIG, cfg(4'h3, 4'hf, m[3:0], 4'h0));
			if (m == 0) begin
				@(posedge clock);
				cmpOverPin <= 1'b1;
			end else begin
				adc(8'hff);
			end
			waitN(1'b0, 100);
			chk(32'(gateCmd), 32'(m + 1));
			cmpOverPin <= 1'b0;
			adc(8'h00);
			repeat (40) @(posedge clock);
			rdchk(OFS_STATUS, {26'h0, 3'(m + 1), 2'b10, 1'b0});
			chk({31'h0, faultN}, 32'h0);
			apb(1'b1, OFS_CLEAR, 32'h1);
			@(posedge clock);
			chk({28'h0, gateCmd, faultN}, 32'h1);
		end
		$display("test latched done");
	endtask

	task automatic t_off();
		for (int m = 9; m < 16; m++) begin
			apb(1'b1, OFS_CONFIG, cfg(4'h0, 4'h0, m[3:0], 4'h0));
			adc(8'hff);
			repeat (20) @(posedge clock);
			chk({31'h0, faultN}, 32'h1);
			rdchk(OFS_STATUS, 32'h0);
			adc(8'h00);
		end
		$display("test disabled done");
	endtask

	// limit 1: one timed retry, then the next event latches
	task automatic t_retry();
		apb(1'b1, OFS_RETRY, 32'h10);
		for (int m = 4; m < 8; m++) begin
			apb(1'b1, OFS_CONFIG, cfg(4'h0, 4'h0, m[3:0], 4'h0));
			adc(8'hff);
			waitN(1'b0, 100);
			rdchk(OFS_STATUS, {22'h0, 4'h1, 3'(m - 3), 2'b01, 1'b1});
			waitN(1'b1, 1000);
			chk(32'(n >= 780 && n <= 810), 32'h1);
			waitN(1'b0, 100);
			rdchk(OFS_STATUS, {22'h0, 4'h1, 3'(m - 3), 2'b10, 1'b1});
			apb(1'b1, OFS_CLEAR, 32'h1);
			waitN(1'b0, 100);
			rdchk(OFS_STATUS, {22'h0, 4'h1, 3'(m - 3), 2'b01, 1'b1});
			adc(8'h00);
			apb(1'b1, OFS_CLEAR, 32'h1);
		end
		$display("test retry done");
	endtask

	// a reset in mid-fault must drop the retry count and every register
	task automatic t_rst();
		apb(1'b1, OFS_CONFIG, cfg(4'h0, 4'h0, 4'h4, 4'h0));
		adc(8'hff);
		waitN(1'b0, 100);
		rdchk(OFS_STATUS, {22'h0, 4'h1, 3'h1, 2'b01, 1'b1});
		@(posedge clock);
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		chk({28'h0, gateCmd, faultN}, 32'h1);
		rdchk(OFS_STATUS, 32'h0);
		rdchk(OFS_CONFIG, CONFIG_RESET);
		rdchk(OFS_RETRY, RETRY_RESET);
		chk({28'h0, cmpThreshold}, 32'h0);
		adc(8'h00);
		$display("test reset done");
	endtask

	initial begin
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		t_regs();
		t_thr();
		t_deg();
		t_latch();
		t_off();
		t_retry();
		t_rst();
		summarize();
	end
endmodule
